// [srlc_pkg.sv]
// Constants shared by the switch/regulator control register block
package srlc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] SRLC_CTRL_OFFSET   = 8'h14;
  localparam int         SRLC_RSVD_MSB      = 7;
  localparam int         SRLC_RSVD_LSB      = 6;
  localparam int         SRLC_SEL_BIT       = 5;
  localparam int         SRLC_CODE_MSB      = 4;
  localparam int         SRLC_CODE_LSB      = 0;
  localparam logic [7:0] SRLC_WRITE_MASK    = 8'h3F;
  localparam logic [7:0] SRLC_UNMAPPED_DATA = 8'h00;

  // ---------------------------------------------------------------
  // Reset contents per factory variant
  // ---------------------------------------------------------------
  localparam int         SRLC_NUM_VARIANTS  = 4;
  localparam logic [7:0] SRLC_RESET_VAR0    = 8'h06;
  localparam logic [7:0] SRLC_RESET_VAR1    = 8'h3F;
  localparam logic [7:0] SRLC_RESET_VAR2    = 8'h26;
  localparam logic [7:0] SRLC_RESET_VAR3    = 8'h26;

  // ---------------------------------------------------------------
  // Voltage code map, millivolts
  // ---------------------------------------------------------------
  localparam logic [4:0]  SRLC_SEG1_FIRST   = 5'h09;
  localparam logic [4:0]  SRLC_SEG2_FIRST   = 5'h0D;
  localparam logic [4:0]  SRLC_SEG3_FIRST   = 5'h10;
  localparam logic [11:0] SRLC_SEG0_BASE_MV = 12'h5DC; // 1500
  localparam logic [11:0] SRLC_SEG1_BASE_MV = 12'h7D0; // 2000
  localparam logic [11:0] SRLC_SEG2_BASE_MV = 12'h960; // 2400
  localparam logic [11:0] SRLC_SEG3_BASE_MV = 12'h9F6; // 2550
  localparam logic [11:0] SRLC_FINE_STEP_MV = 12'h032; // 50
  localparam logic [11:0] SRLC_WIDE_STEP_MV = 12'h064; // 100
  localparam logic [11:0] SRLC_OFF_MV       = 12'h000;

  // Function selected by the mode bit
  typedef enum logic {
    SRLC_MODE_SWITCH    = 1'b0,
    SRLC_MODE_REGULATOR = 1'b1
  } srlc_mode_e;

endpackage : srlc_pkg

// [srlc_volt_lut.sv]
// Voltage code to millivolt target lookup with registered output
`timescale 1ns/1ps
`default_nettype none

module srlc_volt_lut
  import srlc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [4:0]  code,
  input  wire logic        regulator_on,
  output var  logic [11:0] target_mv_reg
);

  logic [11:0] target_mv_next;
  logic [11:0] idx;

  // ---------------------------------------------------------------
  // Piecewise map, four linear segments
  // ---------------------------------------------------------------
  // code map
  always_comb begin
    idx = 12'(code);
    if (!regulator_on) begin
      target_mv_next = SRLC_OFF_MV;
    end else if (code < SRLC_SEG1_FIRST) begin
      target_mv_next = SRLC_SEG0_BASE_MV + 12'(idx * SRLC_FINE_STEP_MV);
    end else if (code < SRLC_SEG2_FIRST) begin
      target_mv_next = SRLC_SEG1_BASE_MV
        + 12'((idx - 12'(SRLC_SEG1_FIRST)) * SRLC_WIDE_STEP_MV);
    end else if (code < SRLC_SEG3_FIRST) begin
      target_mv_next = SRLC_SEG2_BASE_MV
        + 12'((idx - 12'(SRLC_SEG2_FIRST)) * SRLC_FINE_STEP_MV);
    end else begin
      target_mv_next = SRLC_SEG3_BASE_MV
        + 12'((idx - 12'(SRLC_SEG3_FIRST)) * SRLC_FINE_STEP_MV);
    end
  end

  // Registered so the analog side sees a glitch-free target
  always_ff @(posedge clk) begin
    if (srst) begin
      target_mv_reg <= SRLC_OFF_MV;
    end else begin
      target_mv_reg <= target_mv_next;
    end
  end

endmodule : srlc_volt_lut
`default_nettype wire

// [srlc_ctrl_reg.sv]
// Protected switch / third regulator control register
`timescale 1ns/1ps
`default_nettype none

module srlc_ctrl_reg
  import srlc_pkg::*;
#(
  parameter int VARIANT = 0
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        write_unlocked,
  output var  logic [7:0]  reg_rdata,
  output var  logic        reg_rd_valid,
  output var  logic        reg_wr_rejected,
  output var  logic        switch_or_regulator_select,
  output var  logic [4:0]  third_regulator_voltage_code,
  output var  logic [11:0] third_regulator_target_mv
);

  // ---------------------------------------------------------------
  // Elaboration checks and variant reset value
  // ---------------------------------------------------------------
  if (VARIANT < 0 || VARIANT >= SRLC_NUM_VARIANTS) begin : g_bad_variant
    $error("VARIANT must select one of the factory variants");
  end

  localparam logic [7:0] RESET_VALUE =
    (VARIANT == 0) ? SRLC_RESET_VAR0 :
    (VARIANT == 1) ? SRLC_RESET_VAR1 :
    (VARIANT == 2) ? SRLC_RESET_VAR2 : SRLC_RESET_VAR3;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic       hit;
  logic       wr_accept;
  logic       wr_reject;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;

  assign hit       = (reg_addr == SRLC_CTRL_OFFSET);
  assign wr_accept = reg_wr_en && hit && write_unlocked;
  assign wr_reject = reg_wr_en && hit && !write_unlocked;

  assign ctrl_next = reg_wdata & SRLC_WRITE_MASK;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Only the writable bits are ever loaded, so bits 7:6 stay zero
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= RESET_VALUE & SRLC_WRITE_MASK;
    end else if (wr_accept) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Mode and code outputs, a flop copy of the stored fields
  // mode select
  always_ff @(posedge clk) begin
    if (srst) begin
      switch_or_regulator_select <= RESET_VALUE[SRLC_SEL_BIT];
      third_regulator_voltage_code <=
        RESET_VALUE[SRLC_CODE_MSB:SRLC_CODE_LSB];
    end else if (wr_accept) begin
      switch_or_regulator_select <= ctrl_next[SRLC_SEL_BIT];
      third_regulator_voltage_code <=
        ctrl_next[SRLC_CODE_MSB:SRLC_CODE_LSB];
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Read returns the value stored before a same-cycle write
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= hit ? ctrl_reg : SRLC_UNMAPPED_DATA;
      end
    end
  end

  // Rejection flag, one-cycle pulse for diagnostics
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_wr_rejected <= 1'b0;
    end else begin
      reg_wr_rejected <= wr_reject;
    end
  end

  // ---------------------------------------------------------------
  // Voltage target
  // ---------------------------------------------------------------
  // code applies only in regulator mode
  srlc_volt_lut u_lut (
    .clk           (clk),
    .srst          (srst),
    .code          (third_regulator_voltage_code),
    .regulator_on  (switch_or_regulator_select == SRLC_MODE_REGULATOR),
    .target_mv_reg (third_regulator_target_mv)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_good_write;
    reg_wr_en && reg_addr == SRLC_CTRL_OFFSET && write_unlocked;
  endsequence

  sequence s_bad_write;
    reg_wr_en && reg_addr == SRLC_CTRL_OFFSET && !write_unlocked;
  endsequence

  offset_write_a: assert property (
    s_good_write |=> (ctrl_reg == ($past(reg_wdata) & SRLC_WRITE_MASK)))
    else $error("Unlocked write at control offset not stored");

  reserved_zero_a: assert property (
    reg_rd_valid |-> reg_rdata[SRLC_RSVD_MSB:SRLC_RSVD_LSB] == 2'b00)
    else $error("Reserved bits read nonzero");

  mode_follows_a: assert property (
    s_good_write |=> switch_or_regulator_select ==
      $past(reg_wdata[SRLC_SEL_BIT]))
    else $error("Mode output does not follow written bit");

  switch_off_a: assert property (
    s_good_write ##1 !switch_or_regulator_select
      |=> third_regulator_target_mv == SRLC_OFF_MV)
    else $error("Target voltage nonzero in switch mode");

  // Reset edge excluded: the target is still cleared one cycle after it
  map_top_a: assert property (
    (!srst && switch_or_regulator_select
      && third_regulator_voltage_code == 5'h1F)[*2]
      |-> third_regulator_target_mv == 12'hCE4)
    else $error("Code 31 does not map to 3.3 V");

  map_mid_a: assert property (
    (!srst && switch_or_regulator_select
      && third_regulator_voltage_code == 5'h0C)[*2]
      |-> third_regulator_target_mv == 12'h8FC)
    else $error("Code 12 does not map to 2.3 V");

  reset_value_a: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> ctrl_reg == (RESET_VALUE & SRLC_WRITE_MASK))
    else $error("Reset value does not match variant");

  locked_hold_a: assert property (
    s_bad_write |=> $stable(ctrl_reg) && reg_wr_rejected)
    else $error("Locked write changed register");

  read_back_a: assert property (
    reg_rd_en && reg_addr == SRLC_CTRL_OFFSET
      |=> reg_rd_valid && reg_rdata == $past(ctrl_reg))
    else $error("Read data does not match stored value");

endmodule : srlc_ctrl_reg
`default_nettype wire

// [srlc_ctrl_reg_test.sv]
// Self-checking bench for the switch/regulator control register
`timescale 1ns/1ps
`default_nettype none

module srlc_ctrl_reg_test;
  import srlc_pkg::*;

  // ---------------------------------------------------------------
  // Stimulus, observed outputs and counters
  // ---------------------------------------------------------------
  logic        clk            = 1'b0;
  logic        srst           = 1'b1;
  logic        reg_wr_en      = 1'b0;
  logic        reg_rd_en      = 1'b0;
  logic [7:0]  reg_addr       = 8'h00;
  logic [7:0]  reg_wdata      = 8'h00;
  logic        write_unlocked = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rd_valid;
  logic        reg_wr_rejected;
  logic        sel;
  logic [4:0]  code;
  logic [11:0] mv;
  logic        v1_sel;
  logic [4:0]  v1_code;
  logic [11:0] v1_mv;
  int          error_cnt      = 0;
  int          n_tests        = 0;
  // Rows: written byte beside its millivolt target, segment edges first
  logic [7:0]  wd[12]     = '{8'h20, 8'h21, 8'h28, 8'h29, 8'h2C, 8'h2D,
                              8'h2E, 8'h2F, 8'h30, 8'h3F, 8'hFF, 8'hC6};
  logic [11:0] mv_exp[12] = '{12'h5DC, 12'h60E, 12'h76C, 12'h7D0,
                              12'h8FC, 12'h960, 12'h992, 12'h9C4,
                              12'h9F6, 12'hCE4, 12'hCE4, 12'h000};

  srlc_ctrl_reg #(.VARIANT(0)) i_srlc_ctrl_reg (
    .clk                          (clk),
    .srst                         (srst),
    .reg_wr_en                    (reg_wr_en),
    .reg_rd_en                    (reg_rd_en),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .write_unlocked               (write_unlocked),
    .reg_rdata                    (reg_rdata),
    .reg_rd_valid                 (reg_rd_valid),
    .reg_wr_rejected              (reg_wr_rejected),
    .switch_or_regulator_select   (sel),
    .third_regulator_voltage_code (code),
    .third_regulator_target_mv    (mv)
  );

  // Second variant shares the bus; only its reset contents are compared
  srlc_ctrl_reg #(.VARIANT(1)) i_srlc_ctrl_reg_v1 (
    .clk                          (clk),
    .srst                         (srst),
    .reg_wr_en                    (reg_wr_en),
    .reg_rd_en                    (reg_rd_en),
    .reg_addr                     (reg_addr),
    .reg_wdata                    (reg_wdata),
    .write_unlocked               (write_unlocked),
    .reg_rdata                    (),
    .reg_rd_valid                 (),
    .reg_wr_rejected              (),
    .switch_or_regulator_select   (v1_sel),
    .third_regulator_voltage_code (v1_code),
    .third_regulator_target_mv    (v1_mv)
  );

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [11:0] seen,
                     input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write pulse; returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic u);
    @(posedge clk);
    reg_wr_en      <= 1'b1;
    reg_addr       <= a;
    reg_wdata      <= d;
    write_unlocked <= u;
    @(posedge clk);
    reg_wr_en      <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    chk("rd_valid", reg_rd_valid, 1'b1);
    chk("rdata", reg_rdata, exp);
  endtask : rd

  // Reset state: variant 0 is switch mode, code 6, no target
  task automatic chk_reset();
    chk("rst_sel", sel, 1'b0);
    chk("rst_code", code, 5'h06);
    chk("rst_valid", reg_rd_valid, 1'b0);
    chk("rst_sel_v1", v1_sel, 1'b1);
    chk("rst_code_v1", v1_code, 5'h1F);
    @(posedge clk);
    #1;
    chk("rst_mv", mv, 12'h000);
    chk("rst_mv_v1", v1_mv, 12'hCE4);
  endtask : chk_reset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk_reset();
    rd(SRLC_CTRL_OFFSET, 8'h06);
    $display("test reset done");
    // Table rows: every code segment edge, reserved bits, switch mode
    for (int i = 0; i < 12; i++) begin
      wr(SRLC_CTRL_OFFSET, wd[i], 1'b1);
      chk("sel", sel, wd[i][5]);
      chk("code", code, wd[i][4:0]);
      chk("rejected", reg_wr_rejected, 1'b0);
      @(posedge clk);
      #1;
      chk("target_mv", mv, mv_exp[i]);
      rd(SRLC_CTRL_OFFSET, wd[i] & SRLC_WRITE_MASK);
    end
    $display("test table done");
    // Locked write must leave the value alone
    wr(SRLC_CTRL_OFFSET, 8'h3F, 1'b0);
    chk("lock_rej", reg_wr_rejected, 1'b1);
    chk("lock_sel", sel, 1'b0);
    rd(SRLC_CTRL_OFFSET, 8'h06);
    // Neighbour offset is not this register
    wr(8'h15, 8'h3F, 1'b1);
    chk("other_rej", reg_wr_rejected, 1'b0);
    rd(SRLC_CTRL_OFFSET, 8'h06);
    rd(8'h15, SRLC_UNMAPPED_DATA);
    $display("test refusal done");
    // Read and write together: read returns the old value
    @(posedge clk);
    reg_rd_en      <= 1'b1;
    reg_wr_en      <= 1'b1;
    reg_addr       <= SRLC_CTRL_OFFSET;
    reg_wdata      <= 8'h3F;
    write_unlocked <= 1'b1;
    @(posedge clk);
    reg_rd_en      <= 1'b0;
    reg_wr_en      <= 1'b0;
    #1;
    chk("same_rdata", reg_rdata, 8'h06);
    chk("same_sel", sel, 1'b1);
    @(posedge clk);
    #1;
    chk("same_mv", mv, 12'hCE4);
    // Reset in mid-run restores the variant value
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    chk_reset();
    rd(SRLC_CTRL_OFFSET, 8'h06);
    $display("test overlap and rerun done");
    end_of_test();
  end

  // Watchdog: the sequence needs under a hundred cycles
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

endmodule : srlc_ctrl_reg_test
`default_nettype wire
